// *** bench/gbk_gpio_bank_tb.sv ***
// Bench for the GPIO bank: register bus, pins, events, lines, wake, filter.
// Assumes the power manager model beside the bank and a short filter tick.
module gbk_gpio_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gbk_pkg::*;

  localparam int TICK = 4;

  logic        clk_sys;
  logic        sys_rst;
  gbk_av_req_t av_req;
  logic [31:0] av_readdata;
  logic        av_waitrequest;
  logic [31:0] pin_in;
  logic [31:0] pin_out;
  logic [31:0] pin_oe_n;
  logic        irq_line1;
  logic        irq_line2;
  logic        idle_req;
  logic        idle_ack;
  logic        wake_req;
  logic        go_idle;
  logic [7:0]  wake_cnt;
  logic [7:0]  w0;
  logic [31:0] q;
  int          n_mismatch;
  int          n_tests;
  int          cyc;

  gbk_gpio_bank #(.DB_TICK_CYCLES(TICK)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .av_req(av_req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .irq_line1(irq_line1), .irq_line2(irq_line2),
    .idle_req(idle_req), .idle_ack(idle_ack), .wake_req(wake_req)
  );

  gbk_pm_model pm (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .go_idle(go_idle), .wake_req(wake_req),
    .idle_req(idle_req), .wake_cnt(wake_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon access; waits for waitrequest low with no assumed latency
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    av_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
    do @(posedge clk_sys); while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av_req <= '0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask

  // Pins change, then time for sync, detection and the line
  task automatic ev(input logic [31:0] p);
    pin_in <= p;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(pin_oe_n, 32'hffff_ffff);
    rd(OFS_DIR, DIR_RESET);
    rd(8'hfc, 32'h0000_0000);
    wr(OFS_DIN, 32'h1234_5678);
    rd(OFS_DIN, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_drive();
    wr(OFS_DIR, 32'hffff_0000);
    chk(pin_oe_n, 32'hffff_0000);
    wr(OFS_DOUT, 32'h0000_0101);
    wr(OFS_DOUT_CLR, 32'h0000_0001);
    wr(OFS_DOUT_SET, 32'h0000_800e);
    chk(pin_out, 32'h0000_810e);
    rd(OFS_DOUT_CLR, 32'h0000_810e);
    rd(OFS_DOUT_SET, 32'h0000_810e);
    ev(32'h00a5_0000);
    rd(OFS_DIN, 32'h00a5_0000);
    $display("test drive done");
  endtask

  // Event pins sit in the output half, so detection ignores direction
  task automatic t_events();
    wr(OFS_RISE_SEL, 32'h0000_0021);
    wr(OFS_FALL_SEL, 32'h0000_0022);
    wr(OFS_HIGH_SEL, 32'h0000_0014);
    wr(OFS_LOW_SEL, 32'h0000_0010);
    wr(OFS_ST1, 32'hffff_ffff);
    wr(OFS_ST2, 32'hffff_ffff);
    wr(OFS_MASK1_SET, 32'h0000_000f);
    rd(OFS_MASK1_SET, 32'h0000_000f);
    chk(irq_line1, 1'b0);
    ev(32'h00a5_0007);
    rd(OFS_ST1, 32'h0000_0015);
    rd(OFS_ST2, 32'h0000_0015);
    chk(irq_line1, 1'b1);
    chk(irq_line2, 1'b0);
    ev(32'h00a5_0001);
    wr(OFS_ST1, 32'h0000_0003);
    rd(OFS_ST1, 32'h0000_0014);
    chk(irq_line1, 1'b1);
    wr(OFS_ST1, 32'h0000_0000);
    rd(OFS_ST1, 32'h0000_0014);
    wr(OFS_ST1, 32'h0000_0004);
    rd(OFS_ST1, 32'h0000_0010);
    chk(irq_line1, 1'b0);
    wr(OFS_ST2, 32'h0000_0010);
    wr(OFS_MASK2_SET, 32'h0000_0010);
    rd(OFS_ST2, 32'h0000_0017);
    chk(irq_line2, 1'b1);
    wr(OFS_MASK2_CLR, 32'h0000_0010);
    rd(OFS_MASK2, 32'h0000_0000);
    wr(OFS_MASK1_CLR, 32'h0000_0003);
    rd(OFS_MASK1, 32'h0000_000c);
    ev(32'h00a5_0021);
    rd(OFS_ST1, 32'h0000_0030);
    wr(OFS_ST1, 32'h0000_0020);
    ev(32'h00a5_0001);
    rd(OFS_ST1, 32'h0000_0030);
    wr(OFS_LOW_SEL, 32'h0000_0000);
    wr(OFS_HIGH_SEL, 32'h0000_0004);
    $display("test events done");
  endtask

  task automatic t_wake();
    wr(OFS_WAKE, 32'h0000_0005);
    wr(OFS_WAKE_SET, 32'h0000_000a);
    rd(OFS_WAKE_CLR, 32'h0000_000f);
    wr(OFS_WAKE_CLR, 32'h0000_000a);
    rd(OFS_WAKE_SET, 32'h0000_0005);
    w0 = wake_cnt;
    ev(32'h00a5_0000);
    ev(32'h00a5_0001);
    chk(wake_cnt, w0);
    wr(OFS_SYS_CFG, 32'h0000_0004);
    rd(OFS_SYS_CFG, 32'h0000_0004);
    ev(32'h00a5_0004);
    ev(32'h00a5_0004);
    chk(wake_cnt, w0);
    ev(32'h00a5_0025);
    chk(wake_cnt, w0 + 8'h01);
    ev(32'h00a5_0005);
    chk(wake_cnt, w0 + 8'h01);
    go_idle <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(idle_ack, 1'b0);
    wr(OFS_ST1, 32'hffff_ffff);
    wr(OFS_ST2, 32'hffff_ffff);
    repeat (3) @(posedge clk_sys);
    chk(idle_ack, 1'b1);
    ev(32'h00a5_0004);
    ev(32'h00a5_0005);
    rd(OFS_ST1, 32'h0000_0005);
    rd(OFS_ST2, 32'h0000_0005);
    go_idle <= 1'b0;
    $display("test wake done");
  endtask

  // Glitch shorter than two ticks must never pass a three-tick filter
  task automatic t_filter();
    wr(OFS_FLT_LEN, 32'hffff_ff02);
    rd(OFS_FLT_LEN, 32'h0000_0002);
    wr(OFS_FLT_SEL, 32'h0000_0040);
    repeat (20) @(posedge clk_sys);
    pin_in <= 32'h00a5_0045;
    repeat (6) @(posedge clk_sys);
    ev(32'h00a5_0005);
    ev(32'h00a5_0005);
    rd(OFS_DIN, 32'h00a5_0005);
    pin_in <= 32'h00a5_00c5;
    repeat (3) @(posedge clk_sys);
    rd(OFS_DIN, 32'h00a5_0085);
    repeat (40) @(posedge clk_sys);
    rd(OFS_DIN, 32'h00a5_00c5);
    $display("test filter done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst = 1'b1;
    av_req = '0;
    pin_in = 32'h0000_0000;
    go_idle = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    cyc = 0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_drive();
    t_events();
    t_wake();
    t_filter();
    conclude();
  end
endmodule // gbk_gpio_bank_tb

// *** bench/gbk_pm_model.sv ***
// Power manager model: raises idle on demand, counts wake pulses, wakes the bank.
// Assumes the bank on the same clock, wake_req as one-cycle pulses.
module gbk_pm_model (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       go_idle,
  input  wire logic       wake_req,
  output logic            idle_req,
  output logic [7:0]      wake_cnt
);
  logic woke;

  ////////////////////////////////////////////////////////////////////////////////
  // Once woken, stay awake until software withdraws the idle demand
  always_ff @(posedge clk_sys)
  begin
    woke     <= !sys_rst && go_idle && (woke || wake_req);
    idle_req <= !sys_rst && go_idle && !woke && !wake_req;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wake_cnt <= 8'h00;
    else
      wake_cnt <= wake_cnt + {7'h00, wake_req};
  end
endmodule // gbk_pm_model

// *** common/gbk_pkg.sv ***
// Package for the 32-pin general-purpose I/O bank: offsets, layouts, timing.
// Assumes a 250 MHz interface clock and Avalon-MM with 32-bit data.
package gbk_pkg;

  localparam int          PINS          = 32;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;

  // Register byte offsets, word aligned
  localparam logic [7:0]  OFS_SYS_CFG   = 8'h10;
  localparam logic [7:0]  OFS_ST1       = 8'h18;
  localparam logic [7:0]  OFS_MASK1     = 8'h1c;
  localparam logic [7:0]  OFS_WAKE      = 8'h20;
  localparam logic [7:0]  OFS_ST2       = 8'h28;
  localparam logic [7:0]  OFS_MASK2     = 8'h2c;
  localparam logic [7:0]  OFS_DIR       = 8'h34;
  localparam logic [7:0]  OFS_DIN       = 8'h38;
  localparam logic [7:0]  OFS_DOUT      = 8'h3c;
  localparam logic [7:0]  OFS_LOW_SEL   = 8'h40;
  localparam logic [7:0]  OFS_HIGH_SEL  = 8'h44;
  localparam logic [7:0]  OFS_RISE_SEL  = 8'h48;
  localparam logic [7:0]  OFS_FALL_SEL  = 8'h4c;
  localparam logic [7:0]  OFS_FLT_SEL   = 8'h50;
  localparam logic [7:0]  OFS_FLT_LEN   = 8'h54;
  localparam logic [7:0]  OFS_MASK1_CLR = 8'h60;
  localparam logic [7:0]  OFS_MASK1_SET = 8'h64;
  localparam logic [7:0]  OFS_MASK2_CLR = 8'h70;
  localparam logic [7:0]  OFS_MASK2_SET = 8'h74;
  localparam logic [7:0]  OFS_WAKE_CLR  = 8'h80;
  localparam logic [7:0]  OFS_WAKE_SET  = 8'h84;
  localparam logic [7:0]  OFS_DOUT_CLR  = 8'h90;
  localparam logic [7:0]  OFS_DOUT_SET  = 8'h94;

  // Field positions
  localparam int          WAKE_EN_BIT   = 2;
  localparam int          FLT_LEN_W     = 8;

  // Reset values
  localparam logic [31:0] DIR_RESET     = 32'hffff_ffff;
  localparam logic [31:0] ZERO_RESET    = 32'h0000_0000;

  // Timing
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          DB_PERIOD_NS  = 31000;
  localparam int          DB_TICK_CYC   = (DB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [3:0]        byteenable;
  } gbk_av_req_t;

endpackage

// *** src/gbk_gpio_bank.sv ***
// GPIO bank: pin drive and sampling, event detection, two interrupt lines,
// wake-up request, per-pin debounce; Avalon-MM register slave.
// Assumes pins are asynchronous; power manager and idle request on clk_sys.
module gbk_gpio_bank #(
  parameter int DB_TICK_CYCLES = gbk_pkg::DB_TICK_CYC
) (
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire gbk_pkg::gbk_av_req_t        av_req,
  output logic [gbk_pkg::DATA_W-1:0]       av_readdata,
  output logic                             av_waitrequest,
  input  wire logic [gbk_pkg::PINS-1:0]    pin_in,
  output logic [gbk_pkg::PINS-1:0]         pin_out,
  output logic [gbk_pkg::PINS-1:0]         pin_oe_n,
  output logic                             irq_line1,
  output logic                             irq_line2,
  input  wire logic                        idle_req,
  output logic                             idle_ack,
  output logic                             wake_req
);
  import gbk_pkg::*;

  localparam int TICK_W = $clog2(DB_TICK_CYCLES + 1);

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] upd(input logic [31:0] old, input logic [31:0] wd,
                                      input logic [31:0] m);
    upd = (old & ~m) | (wd & m);
  endfunction

  function automatic logic [31:0] alias_upd(input logic [31:0] old, input logic [7:0] a,
                                            input logic [7:0] a_plain, input logic [7:0] a_clr,
                                            input logic [7:0] a_set, input logic [31:0] wd,
                                            input logic [31:0] m);
    alias_upd = old;
    if (a == a_plain)
      alias_upd = upd(old, wd, m);
    else if (a == a_clr)
      alias_upd = old & ~(wd & m);
    else if (a == a_set)
      alias_upd = old | (wd & m);
  endfunction

  logic [31:0]          line1_irq_mask;
  logic [31:0]          line2_irq_mask;
  logic [31:0]          wake_mask;
  logic [31:0]          line1_event_flags;
  logic [31:0]          line2_event_flags;
  logic [31:0]          pin_direction;
  logic [31:0]          pin_drive_value;
  logic [31:0]          pin_sampled_value;
  logic [31:0]          low_level_select;
  logic [31:0]          high_level_select;
  logic [31:0]          rise_edge_select;
  logic [31:0]          fall_edge_select;
  logic [31:0]          filter_pin_select;
  logic [FLT_LEN_W-1:0] filter_count;
  logic                 global_wake_enable;

  logic [31:0]          sync1;
  logic [31:0]          sync2;
  logic [31:0]          filt;
  logic [FLT_LEN_W-1:0] db_cnt [PINS];
  logic [TICK_W-1:0]    tick_cnt;
  logic                 db_tick;
  logic [31:0]          det_prev;
  logic [31:0]          idle_pend;
  logic [31:0]          wake_src;

  logic                 bus_req;
  logic                 bus_acc;
  logic                 wr_acc;
  logic [7:0]           a;
  logic [31:0]          wd;
  logic [31:0]          wmask;
  logic [31:0]          rd_value;
  logic [31:0]          lvl_evt;
  logic [31:0]          edge_evt;
  logic [31:0]          evt;
  logic [31:0]          wake_evt;
  logic [31:0]          flag_set;
  logic [31:0]          clr1;
  logic [31:0]          clr2;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, then the access completes
  assign bus_req = av_req.read | av_req.write;
  assign bus_acc = bus_req & ~av_waitrequest;
  assign wr_acc  = bus_acc & av_req.write;
  assign a       = av_req.address;
  assign wd      = av_req.writedata;
  assign wmask   = be_mask(av_req.byteenable);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      av_waitrequest <= 1'b1;
    else
      av_waitrequest <= !(bus_req && av_waitrequest);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      av_readdata <= ZERO_RESET;
    else if (bus_req && av_waitrequest && av_req.read)
      av_readdata <= rd_value;
  end

  always_comb
  begin
    rd_value = ZERO_RESET;
    unique case (a)
      OFS_SYS_CFG:   rd_value[WAKE_EN_BIT] = global_wake_enable;
      OFS_ST1:       rd_value = line1_event_flags;
      OFS_ST2:       rd_value = line2_event_flags;
      OFS_MASK1, OFS_MASK1_CLR, OFS_MASK1_SET: rd_value = line1_irq_mask;
      OFS_MASK2, OFS_MASK2_CLR, OFS_MASK2_SET: rd_value = line2_irq_mask;
      OFS_WAKE, OFS_WAKE_CLR, OFS_WAKE_SET:    rd_value = wake_mask;
      OFS_DOUT, OFS_DOUT_CLR, OFS_DOUT_SET:    rd_value = pin_drive_value;
      OFS_DIR:       rd_value = pin_direction;
      OFS_DIN:       rd_value = pin_sampled_value;
      OFS_LOW_SEL:   rd_value = low_level_select;
      OFS_HIGH_SEL:  rd_value = high_level_select;
      OFS_RISE_SEL:  rd_value = rise_edge_select;
      OFS_FALL_SEL:  rd_value = fall_edge_select;
      OFS_FLT_SEL:   rd_value = filter_pin_select;
      OFS_FLT_LEN:   rd_value[FLT_LEN_W-1:0] = filter_count;
      default:       rd_value = ZERO_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain control registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pin_direction      <= DIR_RESET;
      low_level_select   <= ZERO_RESET;
      high_level_select  <= ZERO_RESET;
      rise_edge_select   <= ZERO_RESET;
      fall_edge_select   <= ZERO_RESET;
      filter_pin_select  <= ZERO_RESET;
      filter_count       <= '0;
      global_wake_enable <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (a == OFS_DIR)
        pin_direction <= upd(pin_direction, wd, wmask);
      if (a == OFS_LOW_SEL)
        low_level_select <= upd(low_level_select, wd, wmask);
      if (a == OFS_HIGH_SEL)
        high_level_select <= upd(high_level_select, wd, wmask);
      if (a == OFS_RISE_SEL)
        rise_edge_select <= upd(rise_edge_select, wd, wmask);
      if (a == OFS_FALL_SEL)
        fall_edge_select <= upd(fall_edge_select, wd, wmask);
      if (a == OFS_FLT_SEL)
        filter_pin_select <= upd(filter_pin_select, wd, wmask);
      if (a == OFS_FLT_LEN && av_req.byteenable[0])
        filter_count <= wd[FLT_LEN_W-1:0];
      if (a == OFS_SYS_CFG && av_req.byteenable[0])
        global_wake_enable <= wd[WAKE_EN_BIT];
    end
  end

  // Registers with set and clear aliases
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      line1_irq_mask  <= ZERO_RESET;
      line2_irq_mask  <= ZERO_RESET;
      wake_mask       <= ZERO_RESET;
      pin_drive_value <= ZERO_RESET;
    end
    else if (wr_acc)
    begin
      line1_irq_mask  <= alias_upd(line1_irq_mask, a, OFS_MASK1, OFS_MASK1_CLR,
                                   OFS_MASK1_SET, wd, wmask);
      line2_irq_mask  <= alias_upd(line2_irq_mask, a, OFS_MASK2, OFS_MASK2_CLR,
                                   OFS_MASK2_SET, wd, wmask);
      wake_mask       <= alias_upd(wake_mask, a, OFS_WAKE, OFS_WAKE_CLR,
                                   OFS_WAKE_SET, wd, wmask);
      pin_drive_value <= alias_upd(pin_drive_value, a, OFS_DOUT, OFS_DOUT_CLR,
                                   OFS_DOUT_SET, wd, wmask);
    end
  end

  // Pads: direction is only passed out and read back, no other logic inside reads it
  assign pin_out  = pin_drive_value;
  assign pin_oe_n = pin_direction;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser and debounce filter
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sync1 <= ZERO_RESET;
      sync2 <= ZERO_RESET;
    end
    else
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
    end
  end

  // Tick derived from clk_sys; avoids a second clock domain for 32 kHz
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      tick_cnt <= '0;
      db_tick  <= 1'b0;
    end
    else if (tick_cnt == TICK_W'(DB_TICK_CYCLES - 1))
    begin
      tick_cnt <= '0;
      db_tick  <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 1'b1;
      db_tick  <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      filt <= ZERO_RESET;
      for (int i = 0; i < PINS; i++)
        db_cnt[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < PINS; i++)
      begin
        if (sync2[i] == filt[i])
          db_cnt[i] <= '0;
        else if (db_tick)
        begin
          if (db_cnt[i] == filter_count)
          begin
            filt[i]   <= sync2[i];
            db_cnt[i] <= '0;
          end
          else
            db_cnt[i] <= db_cnt[i] + 1'b1;
        end
      end
    end
  end

  assign pin_sampled_value = (filt & filter_pin_select) | (sync2 & ~filter_pin_select);

  ////////////////////////////////////////////////////////////////////////////
  // Event detection
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      det_prev <= ZERO_RESET;
    else
      det_prev <= pin_sampled_value;
  end

  assign lvl_evt  = (~pin_sampled_value & low_level_select)
                  | (pin_sampled_value & high_level_select);
  assign edge_evt = (pin_sampled_value & ~det_prev & rise_edge_select)
                  | (~pin_sampled_value & det_prev & fall_edge_select);
  assign evt      = lvl_evt | edge_evt;
  assign wake_evt = edge_evt & wake_mask & {PINS{global_wake_enable}};

  // Flags only from events; idle events wait until the bank is awake
  assign flag_set = idle_req ? ZERO_RESET : (evt | idle_pend);
  assign clr1     = (wr_acc && a == OFS_ST1) ? (wd & wmask) : ZERO_RESET;
  assign clr2     = (wr_acc && a == OFS_ST2) ? (wd & wmask) : ZERO_RESET;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      idle_pend <= ZERO_RESET;
    else if (idle_req)
      idle_pend <= idle_pend | evt;
    else
      idle_pend <= ZERO_RESET;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      line1_event_flags <= ZERO_RESET;
      line2_event_flags <= ZERO_RESET;
    end
    else
    begin
      line1_event_flags <= (line1_event_flags & ~clr1) | flag_set;
      line2_event_flags <= (line2_event_flags & ~clr2) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt lines, wake-up and idle handshake
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_line1 <= 1'b0;
      irq_line2 <= 1'b0;
    end
    else
    begin
      irq_line1 <= |(line1_event_flags & line1_irq_mask);
      irq_line2 <= |(line2_event_flags & line2_irq_mask);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wake_req <= 1'b0;
      wake_src <= ZERO_RESET;
      idle_ack <= 1'b0;
    end
    else
    begin
      wake_req <= |wake_evt;
      wake_src <= (wake_src & (line1_event_flags | line2_event_flags | idle_pend)) | wake_evt;
      idle_ack <= idle_req
                & ~|(wake_src & (line1_event_flags | line2_event_flags | idle_pend));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_st1_write;
    wr_acc && a == OFS_ST1 && !(|flag_set);
  endsequence

  sequence s_dout_set;
    wr_acc && a == OFS_DOUT_SET;
  endsequence

  property p_irq1_masked;
    irq_line1 |-> $past(|(line1_event_flags & line1_irq_mask));
  endproperty
  a_irq1_masked: assert property (p_irq1_masked) else $error("line1 irq without enabled flag");

  property p_w1c;
    s_st1_write |=> ((line1_event_flags & $past(wd & wmask)) == 32'h0000_0000);
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by write one");

  property p_no_sw_set;
    (|(line2_event_flags & ~$past(line2_event_flags))) |-> $past(|flag_set);
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("flag rose without event");

  property p_dir_reset;
    $past(sys_rst) |-> (pin_oe_n == 32'hffff_ffff);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("pins not inputs after reset");

  property p_sample_lat;
    (filter_pin_select == 32'h0000_0000) [*3] |-> (pin_sampled_value == $past(pin_in, 2));
  endproperty
  a_sample_lat: assert property (p_sample_lat) else $error("input not seen after two clocks");

  property p_no_wake_global;
    !global_wake_enable |=> !wake_req;
  endproperty
  a_no_wake_global: assert property (p_no_wake_global) else $error("wake with global off");

  property p_idle_refuse;
    idle_ack |-> $past(!(|(wake_src & (line1_event_flags | line2_event_flags | idle_pend))));
  endproperty
  a_idle_refuse: assert property (p_idle_refuse) else $error("idle acked with wake flag");

  property p_set_alias;
    s_dout_set |=> ((pin_drive_value & $past(wd & wmask)) == $past(wd & wmask))
                 && ((pin_drive_value & ~$past(wd & wmask))
                     == ($past(pin_drive_value) & ~$past(wd & wmask)));
  endproperty
  a_set_alias: assert property (p_set_alias) else $error("set alias wrong");

  property p_idle_merge;
    (!idle_req && |idle_pend) |=> ((line1_event_flags & $past(idle_pend)) == $past(idle_pend))
                               && ((line2_event_flags & $past(idle_pend)) == $past(idle_pend));
  endproperty
  a_idle_merge: assert property (p_idle_merge) else $error("idle events not merged");

  property p_both_edges;
    (rise_edge_select[5] && fall_edge_select[5] && !idle_req
     && (pin_sampled_value[5] != det_prev[5])) |=> line1_event_flags[5];
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("transition missed");

endmodule // gbk_gpio_bank
